// ===== common/tpdcfg_pkg.sv
// package: object indices, defaults, codes and carrier types of the tpdo mapping and node configuration block
package tpdcfg_pkg;
  // ****************************************
  // object indices
  // ****************************************
  localparam logic [15:0] IDX_TX1_COMM = 16'h1800;
  localparam logic [15:0] IDX_TX2_COMM = 16'h1801;
  localparam logic [15:0] IDX_TX1_MAP = 16'h1a00;
  localparam logic [15:0] IDX_TX2_MAP = 16'h1a01;
  localparam logic [15:0] IDX_STARTUP = 16'h1f80;
  localparam logic [15:0] IDX_NODE_ID = 16'h3000;
  localparam logic [15:0] IDX_BIT_RATE = 16'h3001;
  localparam logic [15:0] IDX_TERM = 16'h3003;
  localparam logic [15:0] IDX_PROFILE = 16'h3004;
  localparam logic [15:0] IDX_FUNC_MODE = 16'h3007;
  localparam logic [15:0] IDX_AVERAGE = 16'h300d;
  localparam logic [15:0] IDX_FILTER = 16'h300e;
  localparam logic [15:0] IDX_ZERO = 16'h300f;
  localparam logic [15:0] IDX_ERR_MASK = 16'h301e;
  localparam logic [15:0] IDX_STATUS = 16'h301f;
  // ****************************************
  // values after reset and limits
  // ****************************************
  localparam logic [31:0] RST_STARTUP = 32'h0000_0000;
  localparam logic [31:0] STARTUP_PREOP = 32'h0000_0004;
  localparam logic [7:0] RST_NODE_ID = 8'h01;
  localparam logic [7:0] NODE_ID_MAX = 8'h7f;
  localparam logic [7:0] RST_BIT_RATE = 8'h03;
  localparam logic [7:0] BIT_RATE_MAX = 8'h08;
  localparam logic [7:0] RST_TERM = 8'h00;
  localparam logic [7:0] RST_PROFILE = 8'h01;
  localparam logic [7:0] PROFILE_MAX = 8'h03;
  localparam logic [7:0] RST_FUNC_MODE = 8'h00;
  localparam logic [7:0] FUNC_MODE_MAX = 8'h05;
  localparam logic [7:0] FUNC_MODE_USER = 8'hff;
  localparam logic [7:0] RST_AVERAGE = 8'h00;
  localparam logic [15:0] RST_FILTER = 16'h0000;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [31:0] RST_ERR_MASK = 32'h0000_0000;
  localparam logic [31:0] COBID_TX1_BASE = 32'h0000_0180;
  localparam logic [31:0] COBID_TX2_BASE = 32'h0000_0280;
  localparam int COBID_OFF_BIT = 31;
  localparam logic [31:0] MAP_X_AXIS = 32'h6010_0010;
  localparam logic [31:0] MAP_Y_AXIS = 32'h6020_0010;
  localparam int MAP_ENTRIES = 8;
  localparam logic [9:0] MAP_MAX_BITS = 10'h040;
  localparam logic [7:0] AVERAGE_SUBS = 8'h02;
  localparam logic [7:0] STATUS_SUBS = 8'h04;
  localparam logic [7:0] HB_BOOT = 8'h00;
  localparam logic [7:0] HB_STOPPED = 8'h04;
  localparam logic [7:0] HB_OPERATIONAL = 8'h05;
  localparam logic [7:0] HB_PREOP = 8'h7f;
  // ****************************************
  // access abort codes
  // ****************************************
  localparam logic [31:0] AB_NONE = 32'h0000_0000;
  localparam logic [31:0] AB_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] AB_NO_SUB = 32'h0609_0011;
  localparam logic [31:0] AB_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] AB_RANGE = 32'h0609_0030;
  localparam logic [31:0] AB_MAP_LEN = 32'h0604_0042;
  localparam logic [31:0] AB_STATE = 32'h0800_0022;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    NMT_BOOT = 2'b00,
    NMT_PREOP = 2'b01,
    NMT_OPER = 2'b11,
    NMT_STOPPED = 2'b10
  } tpdcfg_nmt_t;
  typedef struct packed {
    logic [15:0] index;
    logic [7:0] sub;
    logic wr;
    logic [31:0] wdata;
  } tpdcfg_req_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic [31:0] abort;
  } tpdcfg_rsp_t;
endpackage

// ===== hw/tpdcfg_node.sv
// module: object dictionary configuration and tpdo mapping of the inclinometer node
`timescale 1ns/1ps
module tpdcfg_node (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // dictionary access
  input wire logic req_valid,
  input wire tpdcfg_pkg::tpdcfg_req_t req,
  output logic rsp_valid,
  output tpdcfg_pkg::tpdcfg_rsp_t rsp,
  // node environment
  input wire logic dual_axis_pin,
  input wire logic self_test_pass,
  input wire logic nmt_go_oper,
  input wire logic nmt_go_preop,
  input wire logic nmt_go_stop,
  input wire logic [31:0] mfr_status,
  // node state and settings
  output tpdcfg_pkg::tpdcfg_nmt_t nmt_state,
  output logic [7:0] heartbeat_state,
  output logic tx1_send_en,
  output logic tx2_send_en,
  output logic [10:0] tx1_can_id,
  output logic [10:0] tx2_can_id,
  output logic [7:0] node_id,
  output logic [9:0] bit_rate_kbps,
  output logic terminator_on,
  output logic [1:0] profile,
  output logic [7:0] function_mode,
  output logic [7:0] average_tx1,
  output logic [7:0] average_tx2,
  output logic [15:0] filter_tau,
  output logic zero_x,
  output logic zero_y,
  output logic mfr_error
);
  // ****************************************
  // storage
  // ****************************************
  tpdcfg_pkg::tpdcfg_nmt_t state_ff;
  logic [2:0] axis_sync_ff;
  logic dual_axis_ff;
  logic [31:0] startup_ff;
  logic [7:0] node_id_ff;
  logic [7:0] bit_rate_ff;
  logic [7:0] term_ff;
  logic [7:0] profile_ff;
  logic [7:0] mode_ff;
  logic [7:0] avg1_ff;
  logic [7:0] avg2_ff;
  logic [15:0] tau_ff;
  logic [7:0] zero_ff;
  logic [31:0] mask_ff;
  logic [31:0] cobid_ff [2];
  logic [7:0] count_ff [2];
  localparam int MAP_ENTRIES_W = tpdcfg_pkg::MAP_ENTRIES;
  logic [MAP_ENTRIES_W-1:0][31:0] map_ff [2];
  logic zero_x_ff;
  logic zero_y_ff;
  logic mfr_error_ff;
  logic [9:0] kbps_ff;
  logic tx1_en_ff;
  logic tx2_en_ff;
  logic rsp_valid_ff;
  tpdcfg_pkg::tpdcfg_rsp_t rsp_ff;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [9:0] map_bits(input logic [MAP_ENTRIES_W-1:0][31:0] m, input logic [7:0] n);
    logic [9:0] s;
    s = 10'h000;
    for (int i = 0; i < MAP_ENTRIES_W; i++) begin
      if (8'(i) < n) begin
        s = s + {2'b00, m[i][7:0]};
      end
    end
    return s;
  endfunction
  function automatic logic [9:0] rate_kbps(input logic [7:0] code);
    case (code)
      8'h00: return 10'h3e8;
      8'h01: return 10'h320;
      8'h02: return 10'h1f4;
      8'h03: return 10'h0fa;
      8'h04: return 10'h07d;
      8'h05: return 10'h064;
      8'h06: return 10'h032;
      8'h07: return 10'h014;
      default: return 10'h00a;
    endcase
  endfunction
  // ****************************************
  // dictionary decode
  // ****************************************
  logic wr_ok;
  logic [31:0] rd_val;
  logic [31:0] ab_val;
  logic obj;
  logic remap_state;
  logic [7:0] wbyte;
  assign remap_state = (state_ff == tpdcfg_pkg::NMT_PREOP) || (state_ff == tpdcfg_pkg::NMT_OPER);
  assign wbyte = req.wdata[7:0];
  assign obj = req.index[0];
  always_comb begin
    wr_ok = 1'b0;
    rd_val = 32'h0000_0000;
    ab_val = tpdcfg_pkg::AB_NONE;
    case (req.index)
      tpdcfg_pkg::IDX_TX1_MAP, tpdcfg_pkg::IDX_TX2_MAP: begin
        if (req.sub == 8'h00) begin
          rd_val = {24'h000000, count_ff[obj]};
          if (req.wr) begin
            if (!remap_state) begin
              ab_val = tpdcfg_pkg::AB_STATE;
            end else if (req.wdata > 32'(tpdcfg_pkg::MAP_ENTRIES) ||
                         map_bits(map_ff[obj], wbyte) > tpdcfg_pkg::MAP_MAX_BITS) begin
              ab_val = tpdcfg_pkg::AB_MAP_LEN;
            end else begin
              wr_ok = 1'b1;
            end
          end
        end else if (req.sub <= 8'(tpdcfg_pkg::MAP_ENTRIES)) begin
          rd_val = map_ff[obj][3'(req.sub - 8'h01)];
          if (req.wr) begin
            if (!remap_state || count_ff[obj] != 8'h00) begin
              ab_val = tpdcfg_pkg::AB_STATE;
            end else begin
              wr_ok = 1'b1;
            end
          end
        end else begin
          ab_val = tpdcfg_pkg::AB_NO_SUB;
        end
      end
      tpdcfg_pkg::IDX_TX1_COMM, tpdcfg_pkg::IDX_TX2_COMM: begin
        if (req.sub == 8'h01) begin
          rd_val = cobid_ff[obj];
          wr_ok = req.wr;
        end else begin
          ab_val = tpdcfg_pkg::AB_NO_SUB;
        end
      end
      tpdcfg_pkg::IDX_STARTUP: begin
        rd_val = startup_ff;
        if (req.wr && req.wdata != tpdcfg_pkg::RST_STARTUP && req.wdata != tpdcfg_pkg::STARTUP_PREOP) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_NODE_ID: begin
        rd_val = {24'h000000, node_id_ff};
        if (req.wr && (wbyte == 8'h00 || wbyte > tpdcfg_pkg::NODE_ID_MAX)) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_BIT_RATE: begin
        rd_val = {24'h000000, bit_rate_ff};
        if (req.wr && wbyte > tpdcfg_pkg::BIT_RATE_MAX) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_TERM: begin
        rd_val = {24'h000000, term_ff};
        if (req.wr && wbyte > 8'h01) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_PROFILE: begin
        rd_val = {24'h000000, profile_ff};
        if (req.wr && wbyte > tpdcfg_pkg::PROFILE_MAX) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_FUNC_MODE: begin
        rd_val = {24'h000000, mode_ff};
        if (req.wr && wbyte > tpdcfg_pkg::FUNC_MODE_MAX && wbyte != tpdcfg_pkg::FUNC_MODE_USER) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_AVERAGE: begin
        if (req.sub == 8'h00) begin
          rd_val = {24'h000000, tpdcfg_pkg::AVERAGE_SUBS};
          ab_val = req.wr ? tpdcfg_pkg::AB_READ_ONLY : tpdcfg_pkg::AB_NONE;
        end else if (req.sub <= tpdcfg_pkg::AVERAGE_SUBS) begin
          rd_val = {24'h000000, req.sub[1] ? avg2_ff : avg1_ff};
          wr_ok = req.wr;
        end else begin
          ab_val = tpdcfg_pkg::AB_NO_SUB;
        end
      end
      tpdcfg_pkg::IDX_FILTER: begin
        rd_val = {16'h0000, tau_ff};
        wr_ok = req.wr;
      end
      tpdcfg_pkg::IDX_ZERO: begin
        rd_val = {24'h000000, zero_ff};
        if (req.wr && wbyte > 8'h03) begin
          ab_val = tpdcfg_pkg::AB_RANGE;
        end else begin
          wr_ok = req.wr;
        end
      end
      tpdcfg_pkg::IDX_ERR_MASK: begin
        rd_val = mask_ff;
        wr_ok = req.wr;
      end
      tpdcfg_pkg::IDX_STATUS: begin
        if (req.sub > tpdcfg_pkg::STATUS_SUBS) begin
          ab_val = tpdcfg_pkg::AB_NO_SUB;
        end else begin
          if (req.sub == 8'h00) begin
            rd_val = {24'h000000, tpdcfg_pkg::STATUS_SUBS};
          end else begin
            rd_val = {24'h000000, mfr_status[{2'(req.sub - 8'h01), 3'b000} +: 8]};
          end
          ab_val = req.wr ? tpdcfg_pkg::AB_READ_ONLY : tpdcfg_pkg::AB_NONE;
        end
      end
      default: begin
        ab_val = tpdcfg_pkg::AB_NO_OBJECT;
      end
    endcase
  end
  logic we;
  logic mode_reload;
  assign we = req_valid && wr_ok;
  // leaving user mode or picking a fixed mode rebuilds the mapping
  assign mode_reload = (we && req.index == tpdcfg_pkg::IDX_FUNC_MODE && wbyte != tpdcfg_pkg::FUNC_MODE_USER) ||
                       (state_ff == tpdcfg_pkg::NMT_BOOT);
  // ****************************************
  // access answer, one cycle after the request
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= req_valid;
      if (req_valid) begin
        rsp_ff <= '{rdata: rd_val, abort: ab_val};
      end
    end
  end
  // ****************************************
  // axis strap, three flop filter
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      axis_sync_ff <= 3'b000;
      dual_axis_ff <= 1'b0;
    end else begin
      axis_sync_ff <= {axis_sync_ff[1:0], dual_axis_pin};
      if (axis_sync_ff[1] == axis_sync_ff[2]) begin
        dual_axis_ff <= axis_sync_ff[2];
      end
    end
  end
  // ****************************************
  // mapping records
  // ****************************************
  generate
    for (genvar g = 0; g < 2; g++) begin : g_map
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          count_ff[g] <= 8'h00;
          map_ff[g] <= '0;
        end else if (mode_reload) begin
          if (g == 0) begin
            count_ff[g] <= dual_axis_ff ? 8'h02 : 8'h01;
            map_ff[g] <= '0;
            map_ff[g][0] <= tpdcfg_pkg::MAP_X_AXIS;
            map_ff[g][1] <= dual_axis_ff ? tpdcfg_pkg::MAP_Y_AXIS : 32'h0000_0000;
          end else begin
            count_ff[g] <= 8'h00;
            map_ff[g] <= '0;
          end
        end else if (we && req.index[15:1] == tpdcfg_pkg::IDX_TX1_MAP[15:1] && req.index[0] == 1'(g)) begin
          if (req.sub == 8'h00) begin
            count_ff[g] <= wbyte;
          end else begin
            map_ff[g][3'(req.sub - 8'h01)] <= req.wdata;
          end
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cobid_ff[g] <= (g == 0 ? tpdcfg_pkg::COBID_TX1_BASE : tpdcfg_pkg::COBID_TX2_BASE) +
                         {24'h000000, tpdcfg_pkg::RST_NODE_ID};
        end else if (we && req.index[15:1] == tpdcfg_pkg::IDX_TX1_COMM[15:1] && req.index[0] == 1'(g)) begin
          cobid_ff[g] <= req.wdata;
        end
      end
    end
  endgenerate
  // ****************************************
  // network state
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= tpdcfg_pkg::NMT_BOOT;
    end else begin
      case (state_ff)
        tpdcfg_pkg::NMT_BOOT: begin
          if (self_test_pass) begin
            state_ff <= (startup_ff == tpdcfg_pkg::STARTUP_PREOP) ? tpdcfg_pkg::NMT_PREOP : tpdcfg_pkg::NMT_OPER;
          end
        end
        default: begin
          if (nmt_go_stop) begin
            state_ff <= tpdcfg_pkg::NMT_STOPPED;
          end else if (nmt_go_preop) begin
            state_ff <= tpdcfg_pkg::NMT_PREOP;
          end else if (nmt_go_oper) begin
            state_ff <= tpdcfg_pkg::NMT_OPER;
          end
        end
      endcase
    end
  end
  // ****************************************
  // configuration entries
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startup_ff <= tpdcfg_pkg::RST_STARTUP;
      node_id_ff <= tpdcfg_pkg::RST_NODE_ID;
      bit_rate_ff <= tpdcfg_pkg::RST_BIT_RATE;
      term_ff <= tpdcfg_pkg::RST_TERM;
      profile_ff <= tpdcfg_pkg::RST_PROFILE;
      mode_ff <= tpdcfg_pkg::RST_FUNC_MODE;
      avg1_ff <= tpdcfg_pkg::RST_AVERAGE;
      avg2_ff <= tpdcfg_pkg::RST_AVERAGE;
      tau_ff <= tpdcfg_pkg::RST_FILTER;
      zero_ff <= tpdcfg_pkg::RST_ZERO;
      mask_ff <= tpdcfg_pkg::RST_ERR_MASK;
    end else if (we) begin
      case (req.index)
        tpdcfg_pkg::IDX_STARTUP: startup_ff <= req.wdata;
        tpdcfg_pkg::IDX_NODE_ID: node_id_ff <= wbyte;
        tpdcfg_pkg::IDX_BIT_RATE: bit_rate_ff <= wbyte;
        tpdcfg_pkg::IDX_TERM: term_ff <= wbyte;
        tpdcfg_pkg::IDX_PROFILE: profile_ff <= wbyte;
        tpdcfg_pkg::IDX_FUNC_MODE: mode_ff <= wbyte;
        tpdcfg_pkg::IDX_AVERAGE: begin
          if (req.sub[1]) begin
            avg2_ff <= wbyte;
          end else begin
            avg1_ff <= wbyte;
          end
        end
        tpdcfg_pkg::IDX_FILTER: tau_ff <= req.wdata[15:0];
        tpdcfg_pkg::IDX_ZERO: zero_ff <= wbyte;
        tpdcfg_pkg::IDX_ERR_MASK: mask_ff <= req.wdata;
        default: ;
      endcase
    end
  end
  // ****************************************
  // derived outputs
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_x_ff <= 1'b0;
      zero_y_ff <= 1'b0;
    end else begin
      zero_x_ff <= we && req.index == tpdcfg_pkg::IDX_ZERO && wbyte[0];
      zero_y_ff <= we && req.index == tpdcfg_pkg::IDX_ZERO && wbyte[1];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mfr_error_ff <= 1'b0;
      kbps_ff <= 10'h0fa;
      tx1_en_ff <= 1'b0;
      tx2_en_ff <= 1'b0;
    end else begin
      mfr_error_ff <= |(mfr_status & mask_ff);
      kbps_ff <= rate_kbps(bit_rate_ff);
      tx1_en_ff <= state_ff == tpdcfg_pkg::NMT_OPER && !cobid_ff[0][tpdcfg_pkg::COBID_OFF_BIT] &&
                   count_ff[0] != 8'h00;
      tx2_en_ff <= state_ff == tpdcfg_pkg::NMT_OPER && !cobid_ff[1][tpdcfg_pkg::COBID_OFF_BIT] &&
                   count_ff[1] != 8'h00;
    end
  end
  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;
  assign nmt_state = state_ff;
  assign heartbeat_state = (state_ff == tpdcfg_pkg::NMT_OPER) ? tpdcfg_pkg::HB_OPERATIONAL :
                           (state_ff == tpdcfg_pkg::NMT_PREOP) ? tpdcfg_pkg::HB_PREOP :
                           (state_ff == tpdcfg_pkg::NMT_STOPPED) ? tpdcfg_pkg::HB_STOPPED : tpdcfg_pkg::HB_BOOT;
  assign tx1_send_en = tx1_en_ff;
  assign tx2_send_en = tx2_en_ff;
  assign tx1_can_id = cobid_ff[0][10:0];
  assign tx2_can_id = cobid_ff[1][10:0];
  assign node_id = node_id_ff;
  assign bit_rate_kbps = kbps_ff;
  assign terminator_on = term_ff[0];
  assign profile = profile_ff[1:0];
  assign function_mode = mode_ff;
  assign average_tx1 = avg1_ff;
  assign average_tx2 = avg2_ff;
  assign filter_tau = tau_ff;
  assign zero_x = zero_x_ff;
  assign zero_y = zero_y_ff;
  assign mfr_error = mfr_error_ff;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_answer_next_cycle: assert property (req_valid |=> rsp_valid) else $error("answer missing");
  a_entry_write_locked: assert property (req_valid && req.wr && req.index == tpdcfg_pkg::IDX_TX1_MAP &&
    req.sub == 8'h01 && count_ff[0] != 8'h00 |=> rsp.abort == tpdcfg_pkg::AB_STATE && $stable(map_ff[0]))
    else $error("entry write not refused");
  a_boot_to_oper: assert property (state_ff == tpdcfg_pkg::NMT_BOOT && self_test_pass && startup_ff == 32'h0
    |=> state_ff == tpdcfg_pkg::NMT_OPER ##0 heartbeat_state == 8'h05) else $error("no operational start");
  a_boot_to_preop: assert property (state_ff == tpdcfg_pkg::NMT_BOOT && self_test_pass && startup_ff == 32'h4
    |=> state_ff == tpdcfg_pkg::NMT_PREOP) else $error("no pre-operational start");
  a_node_id_range: assert property (node_id_ff >= 8'h01 && node_id_ff <= 8'h7f) else $error("node id out of range");
  a_zero_both_axes: assert property (req_valid && req.wr && req.index == tpdcfg_pkg::IDX_ZERO &&
    req.wdata[7:0] == 8'h03 |=> zero_x && zero_y ##1 !zero_x) else $error("zero adjust pulse wrong");
  a_boot_map_default: assert property (state_ff == tpdcfg_pkg::NMT_BOOT |=> count_ff[1] == 8'h00 &&
    map_ff[0][0] == 32'h6010_0010) else $error("default mapping wrong");
  a_mask_error_out: assert property ((|(mfr_status & mask_ff)) |=> mfr_error) else $error("masked status lost");
  a_count_len_limit: assert property (count_ff[0] != $past(count_ff[0]) && state_ff != tpdcfg_pkg::NMT_BOOT &&
    !$past(mode_reload) |-> map_bits(map_ff[0], count_ff[0]) <= 10'h040) else $error("mapping over 64 bits");
  a_tx_disabled_bit: assert property (cobid_ff[0][31] |=> !tx1_send_en) else $error("disabled object sends");
endmodule

// ===== verif/tpdcfg_master.sv
// master model: issues dictionary accesses one at a time
`timescale 1ns/1ps
module tpdcfg_master (
  // clock
  input wire logic clk,
  // dictionary access
  output logic req_valid,
  output tpdcfg_pkg::tpdcfg_req_t req,
  input wire logic rsp_valid,
  input wire tpdcfg_pkg::tpdcfg_rsp_t rsp
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // strobe for one cycle, then scramble the released data
  task automatic access(input logic [15:0] i, input logic [7:0] s, input logic w, input logic [31:0] d,
      output tpdcfg_pkg::tpdcfg_rsp_t r, output logic got);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{i, s, w, d};
    @(posedge clk);
    req_valid <= 1'b0;
    req.wdata <= ~d;
    got = 1'b0;
    for (n = 0; n < 4 && !got; n++) begin
      #1;
      got = (rsp_valid === 1'b1);
      r = rsp;
      if (!got) @(posedge clk);
    end
  endtask
endmodule

// ===== verif/tpdcfg_node_tb.sv
// testbench: defaults, refusals, start-up, remap and bit-rate decode
`timescale 1ns/1ps
module tpdcfg_node_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stp = 1'b0;
  logic dual = 1'b0;
  logic req_valid, rsp_valid, tx1, tx2, merr, zx, zy, term;
  tpdcfg_pkg::tpdcfg_req_t req;
  tpdcfg_pkg::tpdcfg_rsp_t rsp, r;
  tpdcfg_pkg::tpdcfg_nmt_t nmt;
  logic [7:0] hb, nid, mode, av1, av2;
  logic [10:0] id1, id2;
  logic [1:0] prof;
  logic [15:0] tau;
  logic [9:0] kbps;
  logic [9:0] rates [9] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa, 10'h07d, 10'h064, 10'h032, 10'h014, 10'h00a};
  int bad_count = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  tpdcfg_master i_master (.clk(clk), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  tpdcfg_node i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp), .dual_axis_pin(dual), .self_test_pass(stp), .nmt_go_oper(1'b0), .nmt_go_preop(1'b0),
    .nmt_go_stop(1'b0), .mfr_status(32'h4433_2211), .nmt_state(nmt), .heartbeat_state(hb),
    .tx1_send_en(tx1), .tx2_send_en(tx2), .tx1_can_id(id1), .tx2_can_id(id2), .node_id(nid),
    .bit_rate_kbps(kbps), .terminator_on(term), .profile(prof), .function_mode(mode), .average_tx1(av1),
    .average_tx2(av2), .filter_tau(tau), .zero_x(zx), .zero_y(zy), .mfr_error(merr));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic acc(input logic [15:0] i, input logic [7:0] s, input logic w, input logic [31:0] d);
    logic got;
    i_master.access(i, s, w, d, r, got);
    if (!got) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic [31:0] ab);
    acc(i, s, 1'b1, d);
    chk("abort", r.abort, ab);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] ex);
    acc(i, s, 1'b0, 32'h0);
    chk("rdata", r.rdata, ex);
  endtask
  initial begin
    int k;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rd(16'h1a00, 8'h00, 32'h1);
    rd(16'h1a00, 8'h01, 32'h6010_0010);
    rd(16'h1a01, 8'h00, 32'h0);
    rd(16'h3000, 8'h00, 32'h1);
    rd(16'h3004, 8'h00, 32'h1);
    rd(16'h300d, 8'h02, 32'h0);
    wr(16'h1a00, 8'h00, 32'h0, 32'h0800_0022);
    wr(16'h1f80, 8'h00, 32'h2, 32'h0609_0030);
    stp <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("nmt", 32'(nmt), 32'h3);
    chk("hb", 32'(hb), 32'h5);
    chk("tx1", 32'(tx1), 32'h1);
    chk("id2", 32'(id2), 32'h281);
    chk("tx2", 32'(tx2), 32'h0);
    chk("term", 32'(term), 32'h0);
    chk("prof", 32'(prof), 32'h1);
    chk("mode", 32'(mode), 32'h0);
    chk("avg", 32'({av1, av2}), 32'h0);
    chk("tau", 32'(tau), 32'h0);
    wr(16'h3000, 8'h00, 32'h80, 32'h0609_0030);
    wr(16'h3003, 8'h00, 32'h2, 32'h0609_0030);
    wr(16'h3004, 8'h00, 32'h4, 32'h0609_0030);
    wr(16'h3007, 8'h00, 32'h6, 32'h0609_0030);
    wr(16'h300f, 8'h00, 32'h4, 32'h0609_0030);
    wr(16'h301f, 8'h03, 32'h0, 32'h0601_0002);
    rd(16'h301f, 8'h03, 32'h33);
    wr(16'h3000, 8'h00, 32'h7f, 32'h0);
    wr(16'h3003, 8'h00, 32'h1, 32'h0);
    wr(16'h3004, 8'h00, 32'h3, 32'h0);
    wr(16'h3007, 8'h00, 32'hff, 32'h0);
    wr(16'h300d, 8'h01, 32'h5, 32'h0);
    wr(16'h300d, 8'h02, 32'h6, 32'h0);
    wr(16'h300e, 8'h00, 32'h1234, 32'h0);
    chk("nid", 32'(nid), 32'h7f);
    chk("term", 32'(term), 32'h1);
    chk("prof", 32'(prof), 32'h3);
    chk("mode", 32'(mode), 32'hff);
    chk("avg", 32'({av1, av2}), 32'h0506);
    chk("tau", 32'(tau), 32'h1234);
    wr(16'h300f, 8'h00, 32'h3, 32'h0);
    chk("zero", 32'({zx, zy}), 32'h3);
    @(posedge clk);
    #1;
    chk("zero", 32'({zx, zy}), 32'h0);
    wr(16'h301e, 8'h00, 32'h100, 32'h0);
    @(posedge clk);
    #1;
    chk("merr", 32'(merr), 32'h0);
    wr(16'h301e, 8'h00, 32'h200, 32'h0);
    @(posedge clk);
    #1;
    chk("merr", 32'(merr), 32'h1);
    for (k = 0; k < 9; k++) begin
      wr(16'h3001, 8'h00, 32'(k), 32'h0);
      @(posedge clk);
      #1;
      chk("kbps", 32'(kbps), 32'(rates[k]));
    end
    wr(16'h3001, 8'h00, 32'h9, 32'h0609_0030);
    wr(16'h1800, 8'h01, 32'hc000_0181, 32'h0);
    wr(16'h1a00, 8'h00, 32'h0, 32'h0);
    wr(16'h1a00, 8'h01, 32'h6020_0010, 32'h0);
    wr(16'h1a00, 8'h00, 32'h9, 32'h0604_0042);
    wr(16'h1a00, 8'h00, 32'h1, 32'h0);
    wr(16'h1a00, 8'h01, 32'h6010_0010, 32'h0800_0022);
    chk("tx1", 32'(tx1), 32'h0);
    wr(16'h1800, 8'h01, 32'h4000_0181, 32'h0);
    rd(16'h1a00, 8'h01, 32'h6020_0010);
    chk("tx1", 32'(tx1), 32'h1);
    chk("id1", 32'(id1), 32'h181);
    wr(16'h3007, 8'h00, 32'h1, 32'h0);
    rd(16'h1a00, 8'h01, 32'h6010_0010);
    stp <= 1'b0;
    dual <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("nid", 32'(nid), 32'h1);
    rd(16'h1a00, 8'h00, 32'h2);
    rd(16'h1a00, 8'h02, 32'h6020_0010);
    wr(16'h1f80, 8'h00, 32'h4, 32'h0);
    stp <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("nmt", 32'(nmt), 32'h1);
    wr(16'h1a00, 8'h00, 32'h0, 32'h0);
    report_and_stop();
  end
endmodule
